//--- rtl/ffc_cfg.svh
// constants for the filter fail capture and clear register bank
// Operation
// - The acknowledge register is write-only; reads return zero and change nothing.
// - Writing one to an acknowledge bit clears that unit's status, overrun and overlap flags.
// - The unit count N is one to four; acknowledge bits sit in the low N bits, the rest reserved.
// - On a permission failure or overlap the unit latches address bits 31 to 0 into its low word.
// - Each unit also holds the upper address word of the same captured access.
// - Only the first failure after reset or after the latest acknowledge is captured.
// - Capture happens whatever the action setting, even with the interrupt not driven.
// - While the status flag is set, further failures leave the captured words unchanged.
// - The upper word field is bits N down to 0, holding address bits N+32 to 32; rest reserved.
// - A set status flag means the unit's event is asserted and waits for acknowledge.
`ifndef FFC_CFG_SVH
`define FFC_CFG_SVH
`define FFC_NUM_UNITS    4
`define FFC_ADDR_W       64
`define FFC_OFS_STATUS   12'h000
`define FFC_OFS_MASK     12'h004
`define FFC_OFS_ACK      12'h008
`define FFC_OFS_ACTION   12'h00C
`define FFC_OFS_LOW0     12'h010
`define FFC_OFS_HIGH0    12'h014
`define FFC_UNIT_STRIDE  12'h008
`define FFC_POS_STATUS   0
`define FFC_POS_OVERRUN  8
`define FFC_POS_OVERLAP  16
`define FFC_RST_WORD     32'h0000_0000
`endif

//--- rtl/ffc_pkg.sv
// types for the filter fail capture and clear register bank
package ffc_pkg;
    typedef logic [3:0]  ffc_units_t;
    typedef logic [31:0] ffc_word_t;
    typedef logic [63:0] ffc_addr_t;
    typedef enum logic [1:0] {
        FFC_IDLE   = 2'b01,
        FFC_ACCESS = 2'b10
    } ffc_apb_state_t;
endpackage

//--- rtl/ffc_unit_capture.sv
// one filter unit: flags and first-failure address capture
`timescale 1ns/1ps
`include "ffc_cfg.svh"
module ffc_unit_capture (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               failPulse,
    input  wire logic               overlapPulse,
    input  wire ffc_pkg::ffc_addr_t failAddr,
    input  wire logic               ackPulse,
    output logic                    statusFlag,
    output logic                    overrunFlag,
    output logic                    overlapFlag,
    output ffc_pkg::ffc_addr_t      capAddr
);
    import ffc_pkg::*;

    typedef struct packed {
        logic      status;
        logic      overrun;
        logic      overlap;
        ffc_addr_t addr;
    } ffc_unit_state_t;

    ffc_unit_state_t state_reg;
    ffc_unit_state_t state_next;
    logic            anyFail;

    // capture on first event, flags sticky, set beats acknowledge
    always_comb begin
        anyFail    = failPulse | overlapPulse;
        state_next = state_reg;
        if (ackPulse) begin
            state_next.status  = 1'b0;
            state_next.overrun = 1'b0;
            state_next.overlap = 1'b0;
        end
        if (anyFail) begin
            if (!state_reg.status || ackPulse) begin
                state_next.addr = failAddr;
            end else begin
                state_next.overrun = 1'b1;
            end
            state_next.status = 1'b1;
        end
        if (overlapPulse) begin
            state_next.overlap = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign statusFlag  = state_reg.status;
    assign overrunFlag = state_reg.overrun;
    assign overlapFlag = state_reg.overlap;
    assign capAddr     = state_reg.addr;
endmodule

//--- rtl/ffc_apb_slave.sv
// apb slave handshake: one wait-free access phase, pulses on completion
`timescale 1ns/1ps
`include "ffc_cfg.svh"
module ffc_apb_slave (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    output logic                         wrStrobe,
    output logic                         rdStrobe,
    input  wire logic                    pwrite,
    output ffc_pkg::ffc_apb_state_t      phase
);
    import ffc_pkg::*;

    typedef struct packed {
        ffc_apb_state_t ph;
    } ffc_apb_reg_t;

    ffc_apb_reg_t state_reg;
    ffc_apb_reg_t state_next;

    // track setup and access phase
    always_comb begin
        state_next = state_reg;
        case (state_reg.ph)
            FFC_IDLE: begin
                if (psel && !penable) state_next.ph = FFC_ACCESS;
            end
            FFC_ACCESS: begin
                state_next.ph = FFC_IDLE;
            end
            default: state_next.ph = FFC_IDLE;
        endcase
    end

    // phase register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg.ph <= FFC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // completion strobes, only in an access phase that followed a setup
    assign wrStrobe = psel && penable && pwrite && (state_reg.ph == FFC_ACCESS);
    assign rdStrobe = psel && penable && !pwrite && (state_reg.ph == FFC_ACCESS);
    assign phase    = state_reg.ph;
endmodule

//--- rtl/ffc_top.sv
// filter fail capture and acknowledge register bank with apb access
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ffc_cfg.svh"
module ffc_top (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire ffc_pkg::ffc_units_t regionFail,
    input  wire ffc_pkg::ffc_units_t regionOverlap,
    input  wire ffc_pkg::ffc_addr_t  failAddr0,
    input  wire ffc_pkg::ffc_addr_t  failAddr1,
    input  wire ffc_pkg::ffc_addr_t  failAddr2,
    input  wire ffc_pkg::ffc_addr_t  failAddr3,
    output logic                     filter_irq_out
);
    import ffc_pkg::*;

    localparam int NU = `FFC_NUM_UNITS;

    typedef struct packed {
        ffc_word_t  rdata;
        logic       slvErr;
        ffc_units_t mask;
        ffc_units_t action;
        logic       irq;
        logic       ready;
    } ffc_top_state_t;

    ffc_top_state_t state_reg;
    ffc_top_state_t state_next;

    logic           wrStrobe;
    ffc_units_t     ackBits;
    ffc_units_t     statusV;
    ffc_units_t     overrunV;
    ffc_units_t     overlapV;
    ffc_addr_t      capAddr [NU];
    ffc_addr_t      inAddr  [NU];

    assign inAddr[0] = failAddr0;
    assign inAddr[1] = failAddr1;
    assign inAddr[2] = failAddr2;
    assign inAddr[3] = failAddr3;

    // index of the unit whose low word sits at this offset, or all ones when none
    function automatic int unitLow(input logic [11:0] a);
        int k;
        unitLow = -1;
        for (k = 0; k < NU; k++) begin
            if (a == `FFC_OFS_LOW0 + 12'(k) * `FFC_UNIT_STRIDE) unitLow = k;
        end
    endfunction

    function automatic int unitHigh(input logic [11:0] a);
        int k;
        unitHigh = -1;
        for (k = 0; k < NU; k++) begin
            if (a == `FFC_OFS_HIGH0 + 12'(k) * `FFC_UNIT_STRIDE) unitHigh = k;
        end
    endfunction

    ffc_apb_slave u_apb (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .psel     (psel),
        .penable  (penable),
        .wrStrobe (wrStrobe),
        .rdStrobe (),
        .pwrite   (pwrite),
        .phase    ()
    );

    // acknowledge pulses, only low N bits take effect
    assign ackBits = (wrStrobe && paddr == `FFC_OFS_ACK) ? pwdata[NU-1:0] : '0;

    // one capture unit per filter
    genvar g;
    generate
        for (g = 0; g < NU; g++) begin : gUnit
            ffc_unit_capture u_cap (
                .clk_sys      (clk_sys),
                .rst          (rst),
                .failPulse    (regionFail[g]),
                .overlapPulse (regionOverlap[g]),
                .failAddr     (inAddr[g]),
                .ackPulse     (ackBits[g]),
                .statusFlag   (statusV[g]),
                .overrunFlag  (overrunV[g]),
                .overlapFlag  (overlapV[g]),
                .capAddr      (capAddr[g])
            );
        end
    endgenerate

    // register writes, read data and interrupt
    always_comb begin
        int ul;
        int uh;
        logic hit;
        ul = unitLow(paddr);
        uh = unitHigh(paddr);
        hit = (paddr == `FFC_OFS_STATUS) || (paddr == `FFC_OFS_MASK) ||
              (paddr == `FFC_OFS_ACK) || (paddr == `FFC_OFS_ACTION) || ul >= 0 || uh >= 0;
        state_next = state_reg;
        state_next.slvErr = 1'b0;
        state_next.ready  = 1'b1; // zero wait states, low only in reset
        if (psel && !penable) begin
            state_next.slvErr = !hit;
            state_next.rdata  = `FFC_RST_WORD;
            if (!pwrite) begin
                if (paddr == `FFC_OFS_STATUS) begin
                    state_next.rdata[`FFC_POS_STATUS +: NU]  = statusV;
                    state_next.rdata[`FFC_POS_OVERRUN +: NU] = overrunV;
                    state_next.rdata[`FFC_POS_OVERLAP +: NU] = overlapV;
                end else if (paddr == `FFC_OFS_MASK) begin
                    state_next.rdata[NU-1:0] = state_reg.mask;
                end else if (paddr == `FFC_OFS_ACTION) begin
                    state_next.rdata[NU-1:0] = state_reg.action;
                end else if (paddr == `FFC_OFS_ACK) begin
                    state_next.rdata = `FFC_RST_WORD;
                end else if (ul >= 0) begin
                    state_next.rdata = capAddr[ul][31:0];
                end else if (uh >= 0) begin
                    state_next.rdata[NU:0] = capAddr[uh][32+NU:32];
                end
            end
        end
        if (wrStrobe && paddr == `FFC_OFS_MASK) state_next.mask = pwdata[NU-1:0];
        if (wrStrobe && paddr == `FFC_OFS_ACTION) state_next.action = pwdata[NU-1:0];
        state_next.irq = |(statusV & state_reg.mask & state_reg.action);
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata         = state_reg.rdata;
    assign pslverr        = state_reg.slvErr; // set by the setup edge, stands in access
    assign pready         = state_reg.ready;
    assign filter_irq_out = state_reg.irq;
endmodule

//--- verification/ffc_top_asserts.sv
// port checks for the fail capture bank
`timescale 1ns/1ps
`include "ffc_cfg.svh"
module ffc_checker (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire ffc_pkg::ffc_units_t regionFail,
    input wire ffc_pkg::ffc_units_t regionOverlap,
    input wire ffc_pkg::ffc_addr_t  failAddr0,
    input wire logic                filter_irq_out
);
    import ffc_pkg::*;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic      armedReg;
    ffc_addr_t capReg;
    wire logic [4:0] capHi = capReg[36:32];
    wire logic hit0 = regionFail[0] | regionOverlap[0];
    wire logic acc = psel & penable & pwrite & (paddr == `FFC_OFS_ACK);
    wire logic rdSet = psel & !penable & !pwrite;
    // unit zero reference: capture armed until the first failure
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armedReg <= 1'b1;
            capReg   <= 64'h0;
        end else begin
            if (hit0 && (armedReg || (acc && pwdata[0]))) capReg <= failAddr0;
            armedReg <= (armedReg || (acc && pwdata[0])) && !hit0;
        end
    end
    ack_reads_zero_a: assert property (rdSet && paddr == `FFC_OFS_ACK |=> prdata == 32'h0)
        else $error("ack read not zero");
    ack_clears_irq_a: assert property (acc && pwdata[3:0] == 4'hF && regionFail == 4'h0
        && regionOverlap == 4'h0 |-> ##2 !filter_irq_out) else $error("irq not cleared");
    low_word_a: assert property (rdSet && paddr == `FFC_OFS_LOW0
        |=> prdata == $past(capReg[31:0])) else $error("low word wrong");
    high_word_a: assert property (rdSet && paddr == `FFC_OFS_HIGH0
        |=> prdata == {27'h0, $past(capHi)}) else $error("high word wrong");
    status_flag_a: assert property (rdSet && paddr == `FFC_OFS_STATUS
        |=> prdata[0] != $past(armedReg)) else $error("status flag wrong");
    irq_reset_low_a: assert property ($fell(rst) |-> !filter_irq_out [*2])
        else $error("irq high after reset");
    zero_wait_a: assert property (psel && penable |-> pready) else $error("pready low");
    unmapped_err_a: assert property (psel && !penable && paddr == 12'h0FC |=> pslverr)
        else $error("no error on unmapped");
    cover property (acc && pwdata[0]);
    cover property (hit0 && !armedReg);
    cover property (filter_irq_out);
    cover property (acc && pwdata[0] && hit0);
endmodule
bind ffc_top ffc_checker u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .regionFail(regionFail), .regionOverlap(regionOverlap),
    .failAddr0(failAddr0), .filter_irq_out(filter_irq_out));

//--- verification/filter_fail_capture_clear_bench.sv
// self-checking bench for the fail capture bank
`timescale 1ns/1ps
`include "ffc_cfg.svh"
module filter_fail_capture_clear_bench;
    import ffc_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    ffc_units_t  rf = 4'h0;
    ffc_units_t  ro = 4'h0;
    ffc_addr_t   fa [4] = '{default: 64'h0};
    ffc_addr_t   a;
    logic [31:0] d;
    logic        e;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    ffc_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .regionFail(rf), .regionOverlap(ro), .failAddr0(fa[0]), .failAddr1(fa[1]),
        .failAddr2(fa[2]), .failAddr3(fa[3]), .filter_irq_out(irq));
    // clock
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        cmp(d, exp);
    endtask
    // one-cycle failure pulse, address valid only with it
    task automatic hit(input int u, input logic ov, input ffc_addr_t ad);
        @(posedge clk_sys);
        rf[u] <= !ov;
        ro[u] <= ov;
        fa[u] <= ad;
        @(posedge clk_sys);
        rf    <= 4'h0;
        ro    <= 4'h0;
        fa[u] <= ~ad;
    endtask
    task automatic summarize();
        $display("TB: %0d mismatches, %0d checks", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            summarize();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(`FFC_OFS_STATUS, 32'h0);
        for (int u = 0; u < 4; u++) begin
            a = {32'hABCD_EF10 + u, 32'h8765_4320 + u};
            hit(u, u[0], a);
            hit(u, 1'b0, ~a);
            rdc(`FFC_OFS_LOW0 + 12'(8 * u), a[31:0]);
            rdc(`FFC_OFS_HIGH0 + 12'(8 * u), {27'h0, a[36:32]});
        end
        rdc(`FFC_OFS_STATUS, 32'h000A_0F0F);
        rdc(`FFC_OFS_ACK, 32'h0);
        wr0: apb(1'b1, `FFC_OFS_ACK, 32'hFFFF_FFF0);
        rdc(`FFC_OFS_STATUS, 32'h000A_0F0F);
        rdc(`FFC_OFS_LOW0 + 12'h018, a[31:0]);
        apb(1'b1, `FFC_OFS_ACTION, 32'h0000_000F);
        apb(1'b1, `FFC_OFS_MASK, 32'h0000_0008);
        repeat (3) @(posedge clk_sys);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, `FFC_OFS_ACK, 32'h0000_0008);
        rdc(`FFC_OFS_STATUS, 32'h0002_0707);
        cmp({31'h0, irq}, 32'h0);
        a = 64'h0000_0015_0000_0ABC;
        hit(3, 1'b0, a);
        rdc(`FFC_OFS_LOW0 + 12'h018, a[31:0]);
        rdc(`FFC_OFS_HIGH0 + 12'h018, 32'h0000_0015);
        rdc(`FFC_OFS_STATUS, 32'h0002_070F);
        apb(1'b1, `FFC_OFS_ACK, 32'hFFFF_FFFF);
        rdc(`FFC_OFS_STATUS, 32'h0);
        // acknowledge and failure in one cycle: the set wins and re-captures
        a = 64'h0000_0003_1111_2220;
        hit(0, 1'b0, a);
        a = 64'h0000_0009_3333_4440;
        fork
            apb(1'b1, `FFC_OFS_ACK, 32'h0000_0001);
            begin
                @(posedge clk_sys);
                hit(0, 1'b0, a);
            end
        join
        rdc(`FFC_OFS_STATUS, 32'h0000_0001);
        rdc(`FFC_OFS_LOW0, a[31:0]);
        // reset in mid-run re-arms capture
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        a = 64'h0000_0011_5555_6660;
        hit(0, 1'b0, a);
        rdc(`FFC_OFS_LOW0, a[31:0]);
        rdc(`FFC_OFS_HIGH0, 32'h0000_0011);
        rdc(`FFC_OFS_STATUS, 32'h0000_0001);
        rdc(12'h0FC, 32'h0);
        cmp({31'h0, e}, 32'h1);
        summarize();
    end
endmodule
